// ===== verilog/ibm_config_regs.sv
// Indexed configuration registers of the ISA bridge and the logic they steer.
`include "ibm_cfg.svh"

// How it works
// - Timer config bits 15:2 hold port address.
// - Timer config bit 0 enables port decode.
// - Port write loads count, decrements every 5us.
// - Count freezes at zero; port read returns it.
// - Bit 7 selects 32-bit DMA addressing.
// - Bit 6 enables slowdown switch inputs.
// - Bit 5 is the software slowdown switch.
// - Hold 4us or 8us per 12us.
// - Bit 3 routes pin 0 to strobe 0.
// - Bit 2 routes pin 1 to strobe 1.
// - Muxing clear gives outputs 1:0 only.
// - High output register drives outputs 15:8.
// - Bits 7:6 set CPU wait states.
// - Bits 5:4 set 16-bit DMA waits.
// - Bits 3:2 set 8-bit DMA waits.
// - Bit 1 aligns memory read with I/O read.
// - Bit 0 selects full or half DMA clock.
module ibm_config_regs (
    // Clock and reset
    input  wire logic          mclk,
    input  wire logic          reset_n,
    // Host I/O port access
    input  wire logic [15:0]   io_addr,
    input  wire logic          io_wr,
    input  wire logic          io_rd,
    input  wire logic [7:0]    io_wdata,
    output logic      [7:0]    io_rdata,
    output logic               io_hit,
    // Slowdown
    input  wire logic          hw_slow_switch,
    output logic               cpu_hold,
    // Management outputs
    input  wire logic [7:0]    mgmt_output_lo,
    output logic      [15:8]   mgmt_output_hi,
    output logic               mgmt_pin_0,
    output logic               mgmt_pin_1,
    output logic               mgmt_expand_en,
    // DMA and macrocell timing
    input  wire logic          dma_read_start,
    input  wire logic          dma_read_end,
    output logic               peripheral_io_read_strobe_n,
    output logic               dma_mem_read_strobe_n,
    output logic               dma_addr32,
    output logic               dma_clk_en,
    output logic      [2:0]    cpu_wait_states,
    output logic      [2:0]    dma16_wait_states,
    output logic      [2:0]    dma8_wait_states
);

    // ------------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------------
    logic [7:0]   index_r;
    logic [7:0]   index_nxt;
    logic [7:0]   macro_r;
    logic [7:0]   macro_nxt;
    logic [7:0]   slow_r;
    logic [7:0]   slow_nxt;
    logic [7:0]   mgmt_hi_r;
    logic [7:0]   mgmt_hi_nxt;
    logic [15:0]  tmr_cfg_r;
    logic [15:0]  tmr_cfg_nxt;
    logic         wr_index;
    logic         wr_data;
    logic         rd_data;
    logic         tmr_port_hit;
    logic [7:0]   tmr_count;
    logic [7:0]   rdata_r;
    logic [7:0]   rdata_nxt;

    assign wr_index = io_wr && io_addr == `IBM_PORT_INDEX;
    assign wr_data  = io_wr && io_addr == `IBM_PORT_DATA;
    assign rd_data  = io_rd && io_addr == `IBM_PORT_DATA;
    // Only address bits 15:2 are compared, so the timer owns four ports.
    assign tmr_port_hit = tmr_cfg_r[`IBM_B_TMR_EN] &&
        io_addr[`IBM_F_TMR_BASE] == tmr_cfg_r[`IBM_F_TMR_BASE];

    // Reserved bits are masked on the way in, so a read needs no
    // second mask and can never show a stale reserved value.
    always_comb begin
        index_nxt   = wr_index ? io_wdata : index_r;
        macro_nxt   = macro_r;
        slow_nxt    = slow_r;
        mgmt_hi_nxt = mgmt_hi_r;
        tmr_cfg_nxt = tmr_cfg_r;
        if (wr_data) begin
            case (index_r)
                `IBM_IDX_MACRO:    macro_nxt = io_wdata;
                `IBM_IDX_DMA_SLOW: begin
                    slow_nxt = io_wdata & `IBM_MASK_DMA_SLOW;
                end
                `IBM_IDX_MGMT_HI:  mgmt_hi_nxt = io_wdata;
                `IBM_IDX_TMR_LO:   begin
                    tmr_cfg_nxt[`IBM_F_LO_BYTE] = io_wdata &
                        `IBM_MASK_TMR_LO;
                end
                `IBM_IDX_TMR_HI:   tmr_cfg_nxt[`IBM_F_HI_BYTE] = io_wdata;
                default:           tmr_cfg_nxt = tmr_cfg_r;
            endcase
        end
    end

    always_comb begin
        rdata_nxt = rdata_r;
        if (tmr_port_hit && io_rd) begin
            rdata_nxt = tmr_count;
        end else if (rd_data) begin
            case (index_r)
                `IBM_IDX_MACRO:    rdata_nxt = macro_r;
                `IBM_IDX_DMA_SLOW: rdata_nxt = slow_r;
                `IBM_IDX_MGMT_HI:  rdata_nxt = mgmt_hi_r;
                `IBM_IDX_TMR_LO:   rdata_nxt = tmr_cfg_r[`IBM_F_LO_BYTE];
                `IBM_IDX_TMR_HI:   rdata_nxt = tmr_cfg_r[`IBM_F_HI_BYTE];
                default:           rdata_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            index_r   <= `IBM_RST_INDEX;
            macro_r   <= `IBM_RST_MACRO;
            slow_r    <= `IBM_RST_DMA_SLOW;
            mgmt_hi_r <= `IBM_RST_MGMT_HI;
            tmr_cfg_r <= `IBM_RST_TMR_CFG;
        end else begin
            index_r   <= index_nxt;
            macro_r   <= macro_nxt;
            slow_r    <= slow_nxt;
            mgmt_hi_r <= mgmt_hi_nxt;
            tmr_cfg_r <= tmr_cfg_nxt;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_r <= `IBM_RST_RDATA;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign io_rdata = rdata_r;
    assign io_hit   = tmr_port_hit || rd_data || wr_data || wr_index;

    // ------------------------------------------------------------------
    // Delay timer
    // ------------------------------------------------------------------
    logic        tmr_load;

    // Any port write while the decode matches restarts the count.
    assign tmr_load = tmr_port_hit && io_wr;

    ibm_delay_timer u_timer (
        .mclk       (mclk),
        .reset_n    (reset_n),
        .load       (tmr_load),
        .load_value (io_wdata),
        .count      (tmr_count)
    );

    // ------------------------------------------------------------------
    // Slowdown hold window
    // ------------------------------------------------------------------
    logic [7:0]  win_r;
    logic [7:0]  win_nxt;
    logic        hold_r;
    logic        hold_nxt;
    logic        slow_active;
    logic [7:0]  hold_len;

    // A switch outside the enable has no effect at all.
    // The window runs free, so the first hold after turn-on may be short;
    // in exchange the duty cycle never drifts and needs no restart logic.
    assign slow_active = slow_r[`IBM_B_SLOW_EN] &&
        (slow_r[`IBM_B_SLOW_SW] || hw_slow_switch);
    assign hold_len = slow_r[`IBM_B_HOLD8] ? 8'(`IBM_HOLD8_CYC)
                                           : 8'(`IBM_HOLD4_CYC);

    always_comb begin
        win_nxt = (win_r == 8'(`IBM_PERIOD_CYC - 1)) ? 8'h00
                                                      : win_r + 8'h01;
        hold_nxt = slow_active && win_nxt < hold_len;
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            win_r  <= 8'h00;
            hold_r <= 1'b0;
        end else begin
            win_r  <= win_nxt;
            hold_r <= hold_nxt;
        end
    end

    assign cpu_hold = hold_r;

    // ------------------------------------------------------------------
    // Management outputs
    // ------------------------------------------------------------------
    logic  pin0_r;
    logic  pin0_nxt;
    logic  pin1_r;
    logic  pin1_nxt;

    // In expansion mode the pins become active-low latch strobes. They sit
    // idle high here, because the low output byte that would pulse them is
    // owned outside this block.
    always_comb begin
        pin0_nxt = slow_r[`IBM_B_MUX0] ? 1'b1 : mgmt_output_lo[0];
        pin1_nxt = slow_r[`IBM_B_MUX1] ? 1'b1 : mgmt_output_lo[1];
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            pin0_r <= 1'b1;
            pin1_r <= 1'b1;
        end else begin
            pin0_r <= pin0_nxt;
            pin1_r <= pin1_nxt;
        end
    end

    assign mgmt_pin_0     = pin0_r;
    assign mgmt_pin_1     = pin1_r;
    assign mgmt_expand_en = slow_r[`IBM_B_MUX0];
    assign mgmt_output_hi = mgmt_hi_r;

    // ------------------------------------------------------------------
    // DMA controls
    // ------------------------------------------------------------------
    ibm_pkg::ibm_dma_e  dma_r;
    ibm_pkg::ibm_dma_e  dma_nxt;
    logic               dclk_r;
    logic               dclk_nxt;

    // The strobe timing bit is sampled only when a read starts, so a
    // change in mid-transfer cannot split the two strobes apart.
    always_comb begin
        dma_nxt = dma_r;
        case (dma_r)
            ibm_pkg::IBM_DMA_IDLE: begin
                if (dma_read_start) begin
                    dma_nxt = macro_r[`IBM_B_RDSTROBE] ? ibm_pkg::IBM_DMA_BOTH
                                                       : ibm_pkg::IBM_DMA_IOR;
                end
            end
            ibm_pkg::IBM_DMA_IOR: begin
                dma_nxt = dma_read_end ? ibm_pkg::IBM_DMA_IDLE
                                       : ibm_pkg::IBM_DMA_BOTH;
            end
            ibm_pkg::IBM_DMA_BOTH: begin
                if (dma_read_end) begin
                    dma_nxt = ibm_pkg::IBM_DMA_IDLE;
                end
            end
            default: dma_nxt = ibm_pkg::IBM_DMA_IDLE;
        endcase
        dclk_nxt = macro_r[`IBM_B_DMACLK] ? 1'b1 : ~dclk_r;
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            dma_r  <= ibm_pkg::IBM_DMA_IDLE;
            dclk_r <= 1'b0;
        end else begin
            dma_r  <= dma_nxt;
            dclk_r <= dclk_nxt;
        end
    end

    assign peripheral_io_read_strobe_n = (dma_r == ibm_pkg::IBM_DMA_IDLE);
    assign dma_mem_read_strobe_n = (dma_r != ibm_pkg::IBM_DMA_BOTH);
    assign dma_clk_en  = dclk_r;
    assign dma_addr32  = slow_r[`IBM_B_DMA32];

    // ------------------------------------------------------------------
    // Wait-state outputs
    // ------------------------------------------------------------------
    // The three fields share one encoding, field value plus one, so one
    // loop decodes them; the outputs lag a register write by one clock.
    for (genvar g = 0; g < `IBM_WS_FIELDS; g++) begin : g_ws
        logic [2:0]  ws_r;
        logic [2:0]  ws_nxt;

        always_comb begin
            ws_nxt = {1'b0, macro_r[`IBM_WS_TOP - `IBM_WS_W * g -: `IBM_WS_W]}
                     + `IBM_WS_BASE;
        end

        always_ff @(posedge mclk or negedge reset_n) begin
            if (!reset_n) begin
                ws_r <= (g == 0) ? `IBM_RST_CPU_WS : `IBM_RST_DMA_WS;
            end else begin
                ws_r <= ws_nxt;
            end
        end
    end

    assign cpu_wait_states   = g_ws[0].ws_r;
    assign dma16_wait_states = g_ws[1].ws_r;
    assign dma8_wait_states  = g_ws[2].ws_r;

endmodule

// ===== verilog/ibm_cfg.svh
// Register indices, field positions, reset values and timing constants.
`ifndef IBM_CFG_SVH
`define IBM_CFG_SVH

`define IBM_PORT_INDEX      16'h0022
`define IBM_PORT_DATA       16'h0023
`define IBM_IDX_MACRO       8'h01
`define IBM_IDX_DMA_SLOW    8'h75
`define IBM_IDX_MGMT_HI     8'h76
`define IBM_IDX_TMR_LO      8'h73
`define IBM_IDX_TMR_HI      8'h74

`define IBM_RST_MACRO       8'hC0
`define IBM_RST_DMA_SLOW    8'h00
`define IBM_RST_MGMT_HI     8'hFF
`define IBM_RST_MGMT_LO     8'hFF
`define IBM_RST_TMR_CFG     16'h0000
`define IBM_RST_INDEX       8'h00
`define IBM_RST_RDATA       8'h00
`define IBM_RST_CPU_WS      3'h4
`define IBM_RST_DMA_WS      3'h1

`define IBM_F_TMR_BASE      15:2
`define IBM_F_LO_BYTE       7:0
`define IBM_F_HI_BYTE       15:8
`define IBM_WS_FIELDS       3
`define IBM_WS_TOP          7
`define IBM_WS_W            2
`define IBM_WS_BASE         3'h1

`define IBM_MASK_DMA_SLOW   8'hFC
`define IBM_MASK_TMR_LO     8'hFD

`define IBM_B_DMA32         7
`define IBM_B_SLOW_EN       6
`define IBM_B_SLOW_SW       5
`define IBM_B_HOLD8         4
`define IBM_B_MUX0          3
`define IBM_B_MUX1          2
`define IBM_B_TMR_EN        0
`define IBM_B_RDSTROBE      1
`define IBM_B_DMACLK        0

`define IBM_CLK_NS          50
`define IBM_TICK_NS         5000
`define IBM_TICK_CYC        (`IBM_TICK_NS / `IBM_CLK_NS)
`define IBM_PERIOD_US       12
`define IBM_HOLD4_US        4
`define IBM_HOLD8_US        8
`define IBM_US_CYC          (1000 / `IBM_CLK_NS)
`define IBM_PERIOD_CYC      (`IBM_PERIOD_US * `IBM_US_CYC)
`define IBM_HOLD4_CYC       (`IBM_HOLD4_US * `IBM_US_CYC)
`define IBM_HOLD8_CYC       (`IBM_HOLD8_US * `IBM_US_CYC)

`endif

// ===== verilog/ibm_pkg.sv
// Types shared by the bridge configuration block.
package ibm_pkg;
    typedef logic [7:0]  ibm_byte_t;
    typedef logic [15:0] ibm_addr_t;
    typedef enum logic [1:0] {
        IBM_DMA_IDLE  = 2'b00,
        IBM_DMA_IOR   = 2'b01,
        IBM_DMA_BOTH  = 2'b10
    } ibm_dma_e;
endpackage

// ===== verilog/ibm_delay_timer.sv
// Eight-bit delay timer counting down once every five microseconds.
`include "ibm_cfg.svh"

module ibm_delay_timer (
    // Clock and reset
    input  wire logic          mclk,
    input  wire logic          reset_n,
    // Load and state
    input  wire logic          load,
    input  wire logic [7:0]    load_value,
    output logic      [7:0]    count
);

    logic [7:0]  count_r;
    logic [7:0]  count_nxt;
    logic [7:0]  pre_r;
    logic [7:0]  pre_nxt;
    logic        tick;

    assign tick  = (pre_r == 8'(`IBM_TICK_CYC - 1));
    assign count = count_r;

    always_comb begin
        pre_nxt   = tick ? 8'h00 : pre_r + 8'h01;
        count_nxt = count_r;
        if (load) begin
            // Restarting the prescaler keeps the first interval whole.
            count_nxt = load_value;
            pre_nxt   = 8'h00;
        end else if (tick && count_r != 8'h00) begin
            count_nxt = count_r - 8'h01;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            count_r <= 8'h00;
            pre_r   <= 8'h00;
        end else begin
            count_r <= count_nxt;
            pre_r   <= pre_nxt;
        end
    end

endmodule

// ===== tb/ibm_config_regs_props.sv
// Port-level assertions for the bridge configuration register block.
module ibm_config_regs_props (
    // Clock and reset
    input wire logic        mclk,
    input wire logic        reset_n,
    // Host I/O port access
    input wire logic [15:0] io_addr,
    input wire logic        io_wr,
    input wire logic [7:0]  io_wdata,
    // Slowdown
    input wire logic        cpu_hold,
    // Management outputs
    input wire logic [7:0]  mgmt_output_lo,
    input wire logic [15:8] mgmt_output_hi,
    input wire logic        mgmt_pin_0,
    input wire logic        mgmt_expand_en,
    // DMA and macrocell timing
    input wire logic        dma_read_start,
    input wire logic        peripheral_io_read_strobe_n,
    input wire logic        dma_mem_read_strobe_n,
    input wire logic        dma_addr32,
    input wire logic        dma_clk_en,
    input wire logic [2:0]  cpu_wait_states,
    input wire logic [2:0]  dma16_wait_states,
    input wire logic [2:0]  dma8_wait_states
);
    // ----------------------------------------------------------------
    // Shadow registers
    // ----------------------------------------------------------------
    logic [7:0] idx_r, mac_r, slow_r, hi_r, run_r;
    wire        dat_wr = io_wr && io_addr == 16'h0023;
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            idx_r <= 8'h00;
            mac_r <= 8'hC0;
            slow_r <= 8'h00;
            hi_r <= 8'hFF;
            run_r <= 8'h00;
        end else begin
            run_r <= cpu_hold ? run_r + 8'h01 : 8'h00;
            if (io_wr && io_addr == 16'h0022) idx_r <= io_wdata;
            if (dat_wr && idx_r == 8'h01) mac_r <= io_wdata;
            if (dat_wr && idx_r == 8'h75) slow_r <= io_wdata & 8'hFC;
            if (dat_wr && idx_r == 8'h76) hi_r <= io_wdata;
        end
    end
    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    sequence s_io_only;
        !peripheral_io_read_strobe_n && dma_mem_read_strobe_n;
    endsequence
    a_dma_addr32: assert property ($stable(slow_r) |->
        dma_addr32 == slow_r[7]) else $error("dma_addr32 wrong");
    a_mgmt_high: assert property ($stable(hi_r) |->
        mgmt_output_hi == hi_r) else $error("high outputs wrong");
    a_cpu_wait: assert property ($stable(mac_r) |->
        cpu_wait_states == {1'b0, mac_r[7:6]} + 3'h1) else $error("cpu ws");
    a_dma_wait: assert property ($stable(mac_r) |->
        dma16_wait_states == {1'b0, mac_r[5:4]} + 3'h1 &&
        dma8_wait_states == {1'b0, mac_r[3:2]} + 3'h1) else $error("dma ws");
    a_hold_off: assert property (!slow_r[6] && $past(!slow_r[6]) &&
        $past(!slow_r[6], 2) |-> !cpu_hold) else $error("hold while off");
    a_hold_len: assert property (run_r <= 8'hA0)
        else $error("hold too long");
    a_pin0_pass: assert property ($past(reset_n) && !mgmt_expand_en &&
        $past(!mgmt_expand_en) |-> mgmt_pin_0 == $past(mgmt_output_lo[0]))
        else $error("pin 0 not passing output 0");
    a_rd_same: assert property (dma_read_start && mac_r[1] |=>
        !peripheral_io_read_strobe_n && !dma_mem_read_strobe_n)
        else $error("strobes not together");
    a_rd_late: assert property (dma_read_start && !mac_r[1] |=>
        s_io_only ##1 !dma_mem_read_strobe_n) else $error("late strobe");
    a_clk_full: assert property (mac_r[0] && $past(mac_r[0]) |->
        dma_clk_en) else $error("full rate clock enable");
    a_clk_half: assert property (!mac_r[0] && $past(!mac_r[0]) &&
        $past(!mac_r[0], 2) && $past(reset_n, 2) |->
        dma_clk_en != $past(dma_clk_en)) else $error("half rate clock");
endmodule

bind ibm_config_regs ibm_config_regs_props ibm_config_regs_props_i (.*);

// ===== tb/tb_isa_bridge_misc_config_regs.sv
// Self-checking bench for the bridge configuration register block.
module tb_isa_bridge_misc_config_regs;
    timeunit 1ns;
    timeprecision 1ns;
    logic        mclk = 1'b0, reset_n = 1'b0, io_wr = 1'b0, io_rd = 1'b0;
    logic        hw_slow_switch = 1'b0, dma_read_start = 1'b0;
    logic        dma_read_end = 1'b0, io_hit, cpu_hold, mgmt_pin_0;
    logic        mgmt_pin_1, mgmt_expand_en, dma_addr32, dma_clk_en;
    logic        peripheral_io_read_strobe_n, dma_mem_read_strobe_n;
    logic [15:0] io_addr = 16'h0000, tp;
    logic [7:0]  io_wdata = 8'h00, io_rdata, mgmt_output_lo = 8'h00, v;
    logic [15:8] mgmt_output_hi;
    logic [2:0]  cpu_wait_states, dma16_wait_states, dma8_wait_states;
    logic [7:0]  ix [4] = '{8'h01, 8'h75, 8'h76, 8'h40};
    logic [7:0]  sv [4] = '{8'h60, 8'h70, 8'h20, 8'h40};
    int          n_mismatch = 0, tests_run = 0, cyc = 0;
    int          mdl [logic [7:0]];
    ibm_config_regs ibm_config_regs_i (.*);
    always #25 mclk = ~mclk;
    // ----------------------------------------------------------------
    // Bus tasks and comparisons
    // ----------------------------------------------------------------
    task automatic io(logic [15:0] a, logic w, logic r, logic [7:0] d);
        io_addr = a;
        io_wr = w;
        io_rd = r;
        io_wdata = d;
        @(posedge mclk);
        #1;
        io_wr = 1'b0;
        io_rd = 1'b0;
        @(posedge mclk);
        #1;
    endtask
    task automatic wr(logic [7:0] i, logic [7:0] d);
        io(16'h0022, 1'b1, 1'b0, i);
        io(16'h0023, 1'b1, 1'b0, d);
        if (mdl.exists(i))
            mdl[i] = d & (i == 8'h75 ? 8'hFC : i == 8'h73 ? 8'hFD : 8'hFF);
    endtask
    task automatic chk(logic [7:0] got, logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_reg(logic [7:0] i);
        io(16'h0022, 1'b1, 1'b0, i);
        io(16'h0023, 1'b0, 1'b1, 8'h00);
        chk(io_rdata, mdl.exists(i) ? 8'(mdl[i]) : 8'h00);
    endtask
    task automatic chk_outs();
        int m;
        int s;
        #100;
        m = mdl[8'h01];
        s = mdl[8'h75];
        chk({5'h00, cpu_wait_states}, 8'(m / 64 % 4 + 1));
        chk({5'h00, dma16_wait_states}, 8'(m / 16 % 4 + 1));
        chk({5'h00, dma8_wait_states}, 8'(m / 4 % 4 + 1));
        chk({7'h00, dma_addr32}, 8'(s / 128));
        chk({7'h00, mgmt_expand_en}, 8'(s / 8 % 2));
        chk(mgmt_output_hi, 8'(mdl[8'h76]));
        chk({7'h00, mgmt_pin_0}, {7'h00, s[3] | mgmt_output_lo[0]});
        chk({7'h00, mgmt_pin_1}, {7'h00, s[2] | mgmt_output_lo[1]});
    endtask
    task automatic hold_cnt(int exp);
        int n = 0;
        #24000;
        repeat (240) begin
            #50;
            n += (cpu_hold === 1'b1);
        end
        chk(8'(n), 8'(exp));
    endtask
    task automatic stop_test();
        $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 30000) begin
            n_mismatch++;
            stop_test();
        end
    end
    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        v = 8'($urandom(32'h3580));
        mdl[8'h01] = 8'hC0;
        mdl[8'h75] = 8'h00;
        mdl[8'h76] = 8'hFF;
        mdl[8'h73] = 8'h00;
        mdl[8'h74] = 8'h00;
        repeat (8) @(posedge mclk);
        #1;
        reset_n = 1'b1;
        foreach (ix[k]) chk_reg(ix[k]);
        chk_outs();
        repeat (24) begin
            mgmt_output_lo = 8'($urandom);
            v = ix[$urandom_range(0, 3)];
            wr(v, 8'($urandom));
            chk_reg(v);
            chk_outs();
        end
        tp = {6'($urandom_range(4, 63)), 8'($urandom)} << 2;
        wr(8'h73, tp[7:0] | 8'h03);
        wr(8'h74, tp[15:8]);
        chk_reg(8'h73);
        chk_reg(8'h74);
        io(tp | 16'h0003, 1'b1, 1'b0, 8'h03);
        io(tp, 1'b0, 1'b1, 8'h00);
        chk(io_rdata, 8'h03);
        #(150 * 50);
        io(tp | 16'h0001, 1'b0, 1'b1, 8'h00);
        chk(io_rdata, 8'(3 - 150 / 100));
        #(400 * 50);
        io(tp, 1'b0, 1'b1, 8'h00);
        chk(io_rdata, 8'h00);
        io_addr = tp;
        #1;
        chk({7'h00, io_hit}, 8'h01);
        #49;
        wr(8'h73, tp[7:0]);
        io_addr = tp;
        #1;
        chk({7'h00, io_hit}, 8'h00);
        #49;
        foreach (sv[k]) begin
            hw_slow_switch = (k >= 2);
            wr(8'h75, sv[k]);
            hold_cnt(sv[k][6] ? (sv[k][4] ? 8000 : 4000) / 50 : 0);
        end
        for (int b = 0; b < 2; b++) begin
            wr(8'h01, {6'($urandom), b[0], b[0]});
            v = {7'h00, dma_clk_en};
            #50;
            chk({7'h00, dma_clk_en}, b ? 8'h01 : v ^ 8'h01);
            dma_read_start = 1'b1;
            #50;
            dma_read_start = 1'b0;
            chk({7'h00, peripheral_io_read_strobe_n}, 8'h00);
            chk({7'h00, dma_mem_read_strobe_n}, 8'(1 - b));
            #50;
            chk({7'h00, dma_mem_read_strobe_n}, 8'h00);
            dma_read_end = 1'b1;
            #50;
            dma_read_end = 1'b0;
            #100;
        end
        stop_test();
    end
endmodule
